// file: hdl/trim_lock_pkg.sv
package trim_lock_pkg;

   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [7:0] FACTORY_TEST_ONE_ADDR = 8'h0d;
   localparam logic [7:0] FACTORY_TEST_TWO_ADDR = 8'h0e;
   localparam logic [7:0] BUS_DISABLE_LOCK_ADDR = 8'h0f;
   localparam logic [7:0] X_TRIM_ADDR = 8'h10;
   localparam logic [7:0] Y_TRIM_ADDR = 8'h11;
   localparam logic [7:0] Z_TRIM_ADDR = 8'h12;

   // ************************************************************
   // Values after reset and key codes
   // ************************************************************
   localparam logic [7:0] REG_RESET_VALUE = 8'h00;
   localparam logic [7:0] LOCK_KEY = 8'h1b;
   localparam logic [3:0] FUSE_ACCESS_MODE = 4'hf;

   // ************************************************************
   // Start condition run length
   // ************************************************************
   localparam logic [2:0] START_RUN_LAST = 3'h7;
   localparam logic [2:0] START_RUN_ZERO = 3'h0;

   // Interface state: Gray order along the usual path.
   typedef enum logic [1:0] {
      BUS_ENABLED = 2'b00,
      BUS_DISABLED = 2'b01
   } bus_state_t;

endpackage

// file: hdl/bus_event_if.sv
interface bus_event_if;
   logic start_seen;
   logic other_seen;
   logic run_complete;

   modport source (output start_seen, output other_seen, input run_complete);
   modport counter (input start_seen, input other_seen, output run_complete);
endinterface

// file: hdl/start_run_counter.sv
module start_run_counter
   import trim_lock_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic ce,
   bus_event_if.counter evt
);

   logic [2:0] run_count;
   logic run_done;

   // ************************************************************
   // Unbroken run of start conditions
   // ************************************************************

   // Any other bus activity breaks the run; the eighth start pulses done.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         run_count <= START_RUN_ZERO;
         run_done <= 1'b0;
      end else if (ce) begin
         run_done <= 1'b0;
         if (evt.other_seen) begin
            run_count <= START_RUN_ZERO;
         end else if (evt.start_seen) begin
            if (run_count == START_RUN_LAST) begin
               run_count <= START_RUN_ZERO;
               run_done <= 1'b1;
            end else begin
               run_count <= run_count + 3'h1;
            end
         end
      end
   end

   assign evt.run_complete = run_done;

   // A break resets the count in the next enabled cycle.
   run_break_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (ce && evt.other_seen) |=> (run_count == START_RUN_ZERO && !run_done))
      else $error("Start run not broken by other activity.");

   // The done pulse only follows a start on the last count.
   run_done_a: assert property (@(posedge mclk) disable iff (sys_rst)
      $rose(run_done) |-> $past(run_count) == START_RUN_LAST && $past(evt.start_seen))
      else $error("Start run done without eight starts.");

endmodule // start_run_counter

// file: hdl/trim_lock_regs.sv
module trim_lock_regs
   import trim_lock_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic bus_start,
   input wire logic bus_other,
   input wire logic [3:0] op_mode,
   input wire logic [7:0] fuse_x_trim,
   input wire logic [7:0] fuse_y_trim,
   input wire logic [7:0] fuse_z_trim,
   output logic serial_bus_enable
);

   bus_state_t bus_state;
   logic [7:0] factory_test_one;
   logic [7:0] factory_test_two;
   logic [7:0] serial_bus_disable_lock;
   logic [7:0] next_rdata;
   logic lock_write;
   logic fuse_mode;

   bus_event_if evt ();

   // ************************************************************
   // Bus activity to the start run counter
   // ************************************************************

   // Event pulses are forwarded unchanged; the counter runs in every state.
   assign evt.start_seen = bus_start;
   assign evt.other_seen = bus_other;

   start_run_counter u_start_run (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .ce(ce),
      .evt(evt)
   );

   assign lock_write = reg_write && (reg_addr == BUS_DISABLE_LOCK_ADDR);
   assign fuse_mode = (op_mode == FUSE_ACCESS_MODE);

   // ************************************************************
   // Factory test registers
   // ************************************************************

   // These hold what is written and are only read back; they have no user function.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         factory_test_one <= REG_RESET_VALUE;
         factory_test_two <= REG_RESET_VALUE;
      end else if (ce && reg_write) begin
         if (reg_addr == FACTORY_TEST_ONE_ADDR) begin
            factory_test_one <= reg_wdata;
         end
         if (reg_addr == FACTORY_TEST_TWO_ADDR) begin
            factory_test_two <= reg_wdata;
         end
      end
   end

   // ************************************************************
   // Bus disable lock
   // ************************************************************

   // A key write beats a run completion in the same cycle, but starts taken up to and with the
   // key write still count, so the lock can drop after fewer than eight further starts.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         bus_state <= BUS_ENABLED;
         serial_bus_disable_lock <= REG_RESET_VALUE;
         serial_bus_enable <= 1'b1;
      end else if (ce) begin
         case (bus_state)
            BUS_ENABLED: begin
               if (lock_write) begin
                  serial_bus_disable_lock <= reg_wdata;
                  if (reg_wdata == LOCK_KEY) begin
                     bus_state <= BUS_DISABLED;
                     serial_bus_enable <= 1'b0;
                  end
               end
            end
            BUS_DISABLED: begin
               // Other values cannot be written; only the run or a reset reopens the bus.
               if (evt.run_complete) begin
                  bus_state <= BUS_ENABLED;
                  serial_bus_enable <= 1'b1;
                  serial_bus_disable_lock <= REG_RESET_VALUE;
               end
            end
            default: begin
               bus_state <= BUS_ENABLED;
               serial_bus_enable <= 1'b1;
               serial_bus_disable_lock <= REG_RESET_VALUE;
            end
         endcase
      end
   end

   // ************************************************************
   // Read path
   // ************************************************************

   // Trims are live fuse values and only visible in fuse access mode; other
   // addresses outside this bank read zero.
   // Trims pass unaltered, so the host's positive scale keeps each reading's polarity.
   always_comb begin
      next_rdata = REG_RESET_VALUE;
      case (reg_addr)
         FACTORY_TEST_ONE_ADDR: next_rdata = factory_test_one;
         FACTORY_TEST_TWO_ADDR: next_rdata = factory_test_two;
         BUS_DISABLE_LOCK_ADDR: next_rdata = serial_bus_disable_lock;
         X_TRIM_ADDR: next_rdata = fuse_mode ? fuse_x_trim : REG_RESET_VALUE;
         Y_TRIM_ADDR: next_rdata = fuse_mode ? fuse_y_trim : REG_RESET_VALUE;
         Z_TRIM_ADDR: next_rdata = fuse_mode ? fuse_z_trim : REG_RESET_VALUE;
         default: next_rdata = REG_RESET_VALUE;
      endcase
   end

   // Read data is registered, one cycle after the read strobe.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         reg_rdata <= REG_RESET_VALUE;
         reg_rvalid <= 1'b0;
      end else if (ce) begin
         reg_rvalid <= reg_read;
         if (reg_read) begin
            reg_rdata <= next_rdata;
         end
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************

   sequence key_write_s;
      ce && lock_write && reg_wdata == LOCK_KEY && bus_state == BUS_ENABLED;
   endsequence

   sequence run_reopen_s;
      ce && evt.run_complete && bus_state == BUS_DISABLED;
   endsequence

   lock_key_a: assert property (@(posedge mclk) disable iff (sys_rst)
      key_write_s |=> !serial_bus_enable && serial_bus_disable_lock == LOCK_KEY)
      else $error("Key write did not disable the bus.");

   lock_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (bus_state == BUS_DISABLED && !(ce && evt.run_complete))
      |=> $stable(serial_bus_disable_lock) && !serial_bus_enable)
      else $error("Lock register changed while bus disabled.");

   reopen_run_a: assert property (@(posedge mclk) disable iff (sys_rst)
      run_reopen_s |=> serial_bus_enable && serial_bus_disable_lock == REG_RESET_VALUE)
      else $error("Start run did not re-enable the bus.");

   reset_state_a: assert property (@(posedge mclk)
      sys_rst |=> serial_bus_enable && serial_bus_disable_lock == REG_RESET_VALUE)
      else $error("Bus not enabled after reset.");

   enable_match_a: assert property (@(posedge mclk) disable iff (sys_rst)
      serial_bus_enable == (bus_state == BUS_ENABLED))
      else $error("Enable output disagrees with bus state.");

   trim_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (ce && reg_read && reg_addr == X_TRIM_ADDR && fuse_mode)
      |=> reg_rvalid && reg_rdata == $past(fuse_x_trim))
      else $error("X trim read does not return fuse value.");

   fuse_gate_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (ce && reg_read && reg_addr == Z_TRIM_ADDR && !fuse_mode)
      |=> reg_rdata == REG_RESET_VALUE)
      else $error("Trim visible outside fuse access mode.");

   other_key_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (ce && lock_write && reg_wdata != LOCK_KEY && bus_state == BUS_ENABLED)
      |=> serial_bus_enable)
      else $error("Non-key write disabled the bus.");

   // Writes while locked leave the key in place, whatever value they carry.
   locked_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (ce && lock_write && bus_state == BUS_DISABLED && !evt.run_complete)
      |=> serial_bus_disable_lock == LOCK_KEY && !serial_bus_enable)
      else $error("Write to locked register took effect.");

   // An open bus stores whatever the host writes to the lock register.
   lock_store_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (ce && lock_write && bus_state == BUS_ENABLED)
      |=> serial_bus_disable_lock == $past(reg_wdata))
      else $error("Lock register did not store the written value.");

   // The other two trims follow their fuse inputs in fuse access mode.
   trim_y_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (ce && reg_read && reg_addr == Y_TRIM_ADDR && fuse_mode)
      |=> reg_rvalid && reg_rdata == $past(fuse_y_trim))
      else $error("Y trim read does not return fuse value.");

   trim_z_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (ce && reg_read && reg_addr == Z_TRIM_ADDR && fuse_mode)
      |=> reg_rvalid && reg_rdata == $past(fuse_z_trim))
      else $error("Z trim read does not return fuse value.");

   // Valid follows the read strobe one enabled cycle later and holds its level while ce is low.
   read_pulse_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (ce && !reg_read) |=> !reg_rvalid)
      else $error("Read valid without a read strobe.");

endmodule // trim_lock_regs

// file: bench/host_cpu_model.sv
// ************************************************************
// Host side of the register bus and the serial bus events
// ************************************************************
module host_cpu_model
   import trim_lock_pkg::*;
(
   input wire logic mclk,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_write,
   output logic reg_read,
   output logic bus_start,
   output logic bus_other,
   output logic [3:0] op_mode
);
   timeunit 1ns;
   timeprecision 1ns;

   // All requests idle at time zero so nothing is taken during reset.
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
      bus_start = 1'b0;
      bus_other = 1'b0;
      op_mode = 4'h0;
   end

   // One byte request, raised after an edge and dropped after the edge that takes it; factory test addresses send none.
   task automatic access(input logic [7:0] addr, input logic [7:0] data, input logic wr);
      if (addr == FACTORY_TEST_ONE_ADDR || addr == FACTORY_TEST_TWO_ADDR) return;
      @(posedge mclk);
      #5;
      reg_addr = addr;
      reg_wdata = data;
      reg_write = wr;
      reg_read = !wr;
      @(posedge mclk);
      #5;
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_wdata = ~data; // Released data is scrambled so a late sample cannot match.
   endtask

   // One pulse of a start condition or of other bus activity.
   task automatic bus_event(input logic is_start);
      @(posedge mclk);
      #5;
      bus_start = is_start;
      bus_other = !is_start;
      @(posedge mclk);
      #5;
      bus_start = 1'b0;
      bus_other = 1'b0;
   endtask

   // Mode field write, as the host would put it in the control register.
   task automatic set_mode(input logic [3:0] mode);
      @(posedge mclk);
      #5;
      op_mode = mode;
   endtask

   // Host scaling of an axis reading; the factor stays between one half and one and a half.
   function automatic real adjust_reading(input int reading, input logic [7:0] trim);
      return reading * ((real'(int'(trim) - 128) * 0.5 / 128.0) + 1.0);
   endfunction
endmodule // host_cpu_model

// file: bench/testbench.sv
// ************************************************************
// Self-checking bench for the lock and trim registers
// ************************************************************
module testbench
   import trim_lock_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic ce = 1'b1;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic reg_write, reg_read, reg_rvalid, bus_start, bus_other, serial_bus_enable;
   logic [3:0] op_mode;
   logic [7:0] fuse [3] = '{8'h00, 8'h00, 8'h00};
   logic [7:0] exp_q [$];
   logic [7:0] v;
   int failures = 0;
   int tests_run = 0;
   int seed = 31065;

   always #25 mclk = ~mclk;

   host_cpu_model host_cpu_model_i (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .bus_start(bus_start),
      .bus_other(bus_other), .op_mode(op_mode));

   trim_lock_regs trim_lock_regs_i (.mclk(mclk), .sys_rst(sys_rst), .ce(ce),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .bus_start(bus_start),
      .bus_other(bus_other), .op_mode(op_mode), .fuse_x_trim(fuse[0]),
      .fuse_y_trim(fuse[1]), .fuse_z_trim(fuse[2]), .serial_bus_enable(serial_bus_enable));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("failures %0d tests_run %0d", failures, tests_run);
      if (failures == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // A read notes its expected byte first; the monitor below compares it.
   task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
      exp_q.push_back(exp);
      host_cpu_model_i.access(addr, 8'h00, 1'b0);
   endtask

   // The enable level is judged one whole cycle after the cause has been taken.
   task automatic check_en(input logic exp);
      @(posedge mclk);
      #5;
      check({7'h00, serial_bus_enable}, {7'h00, exp});
   endtask

   // Read data is sampled mid-cycle while the valid pulse stands.
   always @(negedge mclk) begin
      if (reg_rvalid === 1'b1) begin
         if (exp_q.size() == 0)
            check(8'h01, 8'h00);
         else
            check(reg_rdata, exp_q.pop_front());
      end
   end

   // Watchdog sized well past the hundred or so cycles the sequence needs.
   initial begin
      #200000;
      failures++;
      test_done();
   end

   initial begin
      foreach (fuse[i]) fuse[i] = 8'($random(seed));
      repeat (12) @(posedge mclk);
      #5;
      sys_rst = 1'b0;
      check_en(1'b1);
      rd(BUS_DISABLE_LOCK_ADDR, REG_RESET_VALUE);
      v = 8'($random(seed));
      if (v == LOCK_KEY) v = v ^ 8'h01;
      host_cpu_model_i.access(BUS_DISABLE_LOCK_ADDR, v, 1'b1);
      check_en(1'b1);
      rd(BUS_DISABLE_LOCK_ADDR, v);
      host_cpu_model_i.access(BUS_DISABLE_LOCK_ADDR, LOCK_KEY, 1'b1);
      check_en(1'b0);
      host_cpu_model_i.access(BUS_DISABLE_LOCK_ADDR, v, 1'b1);
      host_cpu_model_i.access(BUS_DISABLE_LOCK_ADDR, 8'h00, 1'b1);
      rd(BUS_DISABLE_LOCK_ADDR, LOCK_KEY);
      // Seven starts, a break, then seven more must not reopen the bus.
      repeat (7) host_cpu_model_i.bus_event(1'b1);
      host_cpu_model_i.bus_event(1'b0);
      repeat (7) host_cpu_model_i.bus_event(1'b1);
      check_en(1'b0);
      host_cpu_model_i.bus_event(1'b1);
      @(posedge mclk);
      check_en(1'b1);
      rd(BUS_DISABLE_LOCK_ADDR, REG_RESET_VALUE);
      // Trims show fuse values only in fuse access mode and ignore writes.
      host_cpu_model_i.set_mode(FUSE_ACCESS_MODE);
      host_cpu_model_i.access(X_TRIM_ADDR, ~fuse[0], 1'b1);
      for (int i = 0; i < 3; i++) rd(X_TRIM_ADDR + 8'(i), fuse[i]);
      host_cpu_model_i.set_mode(4'h0);
      rd(Z_TRIM_ADDR, 8'h00);
      rd(8'h13, 8'h00);
      // A frozen block takes no key write; one idle cycle first lets valid drop.
      @(posedge mclk);
      #5;
      ce = 1'b0;
      host_cpu_model_i.access(BUS_DISABLE_LOCK_ADDR, LOCK_KEY, 1'b1);
      check_en(1'b1);
      ce = 1'b1;
      rd(BUS_DISABLE_LOCK_ADDR, REG_RESET_VALUE);
      // A device reset reopens a locked bus.
      host_cpu_model_i.access(BUS_DISABLE_LOCK_ADDR, LOCK_KEY, 1'b1);
      check_en(1'b0);
      @(posedge mclk);
      #5;
      sys_rst = 1'b1;
      @(posedge mclk);
      #5;
      sys_rst = 1'b0;
      check_en(1'b1);
      rd(BUS_DISABLE_LOCK_ADDR, REG_RESET_VALUE);
      repeat (4) @(posedge mclk);
      check(8'(exp_q.size()), 8'h00);
      test_done();
   end
endmodule // testbench
